//--- src/wdt0_unit.sv
/*
 watchdog (basic tick unit) and 8-bit timer 0 with interval, capture and pwm.
 assumes registers are reached over the cpu register port with one-cycle
 write and read strobes, timer pins already synchronous to clk, and clk
 being the oscillator clock.
*/
`timescale 1ns/100ps
module wdt0_unit (
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic [wdt0_pkg::REG_W-1:0] reg_addr,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [wdt0_pkg::REG_W-1:0] reg_wdata,
	output logic      [wdt0_pkg::REG_W-1:0] reg_rdata_r,
	input  wire logic                     stop_req,
	input  wire logic                     ext_wake,
	output logic                          osc_run_r,
	output logic                          cpu_clock_hold_r,
	output logic                          stab_done_r,
	output logic                          wdt_reset_r,
	input  wire logic                     timer_ext_clock_pin,
	input  wire logic                     timer_capture_pin,
	input  wire logic                     wrap_ack,
	output logic                          timer_wrap_interrupt_r,
	output logic                          timer_match_interrupt_r,
	output logic                          timer_pulse_output_r
);
	import wdt0_pkg::*;

	function automatic logic hit(input logic [REG_W-1:0] a, input logic [REG_W-1:0] t);
		return a == t;
	endfunction

	wdt0_state_t          state_r;
	wdt0_state_t          state_nxt;
	logic [PS_TAPS-1:0]   ps_tick;
	logic [7:0]           watchdog_control_r;
	logic [7:0]           watchdog_count_r;
	logic [7:0]           timer_control_r;
	logic [7:0]           timer_reference_value_r;
	logic [7:0]           timer_count_r;
	logic                 match_pend_r;
	logic                 match_pend_nxt;
	logic                 ext_prev_r;
	logic                 cap_prev_r;
	logic                 wr_wd_ctl;
	logic                 wr_t0_ctl;
	logic                 wr_t0_ref;
	logic                 div_clr;
	logic                 wd_clr;
	logic                 t0_clr;
	logic                 run_osc;
	logic                 wd_tick;
	logic                 wd_en;
	logic                 wd_wrap;
	logic                 stab_end;
	logic [1:0]           t0_sel;
	logic [1:0]           t0_mode;
	logic                 t0_tick;
	logic                 t0_eq;
	logic                 t0_match;
	logic                 t0_wrap;
	logic                 cap_edge;

	assign wr_wd_ctl = reg_wr && hit(reg_addr, ADDR_WD_CTL);
	assign wr_t0_ctl = reg_wr && hit(reg_addr, ADDR_T0_CTL);
	assign wr_t0_ref = reg_wr && hit(reg_addr, ADDR_T0_REF);
	assign div_clr   = wr_wd_ctl && reg_wdata[DIV_CLR_BIT];
	assign wd_clr    = wr_wd_ctl && reg_wdata[WD_CNT_CLR_BIT];
	assign t0_clr    = wr_t0_ctl && reg_wdata[T0_CNT_CLR_BIT];
	// oscillator is stopped in stop mode, so no divided tick reaches either counter
	assign run_osc   = (state_r != WD_STOP);

	wdt0_prescaler u_prescaler (
		.clk   (clk),
		.rst_b (rst_b),
		.clear (div_clr),
		.tick  (ps_tick)
	);

	// watchdog side
	always_comb begin
		unique case (watchdog_control_r[WD_SEL_HI:WD_SEL_LO])
			WD_SEL_4096:  wd_tick = ps_tick[TAP_4096];
			WD_SEL_1024:  wd_tick = ps_tick[TAP_1024];
			WD_SEL_128:   wd_tick = ps_tick[TAP_128];
			WD_SEL_16384: wd_tick = ps_tick[TAP_16384];
		endcase
		wd_tick = wd_tick && run_osc;
	end

	assign wd_en    = watchdog_control_r[WD_EN_HI:WD_EN_LO] != WD_DISABLE;
	assign wd_wrap  = wd_tick && (watchdog_count_r == CNT_MAX) && !wd_clr;
	assign stab_end = (state_r == WD_STAB) && wd_tick && !wd_clr
	                  && (watchdog_count_r[STAB_BIT:0] == STAB_LOW_FULL);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_control_r <= REG_RESET;
		end else if (wr_wd_ctl) begin
			// clear bits are strobes only and always read back zero
			watchdog_control_r <= reg_wdata & WD_STORE_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_count_r <= CNT_ZERO;
		end else if (wd_clr) begin
			watchdog_count_r <= CNT_ZERO;
		end else if (state_r == WD_STOP && ext_wake) begin
			// a wake starts the stabilization interval from a known count
			watchdog_count_r <= CNT_ZERO;
		end else if (wd_tick) begin
			watchdog_count_r <= watchdog_count_r + CNT_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdt_reset_r <= 1'b0;
		end else begin
			wdt_reset_r <= wd_wrap && wd_en;
		end
	end

	// stop and stabilization sequencing; reset itself lands in stabilization
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			WD_RUN:  if (stop_req) begin
				state_nxt = WD_STOP;
			end
			WD_STOP: if (ext_wake) begin
				state_nxt = WD_STAB;
			end
			WD_STAB: if (stab_end) begin
				state_nxt = WD_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r          <= WD_STAB;
			osc_run_r        <= 1'b1;
			cpu_clock_hold_r <= 1'b1;
			stab_done_r      <= 1'b0;
		end else begin
			state_r          <= state_nxt;
			osc_run_r        <= (state_nxt != WD_STOP);
			cpu_clock_hold_r <= (state_nxt != WD_RUN);
			stab_done_r      <= stab_end;
		end
	end

	// timer 0 side
	assign t0_sel  = timer_control_r[T0_SEL_HI:T0_SEL_LO];
	assign t0_mode = timer_control_r[T0_MODE_HI:T0_MODE_LO];

	always_comb begin
		unique case (t0_sel)
			T0_SEL_4096: t0_tick = ps_tick[TAP_4096];
			T0_SEL_256:  t0_tick = ps_tick[TAP_256];
			T0_SEL_8:    t0_tick = ps_tick[TAP_8];
			T0_SEL_EXT:  t0_tick = timer_ext_clock_pin && !ext_prev_r;
		endcase
		t0_tick = t0_tick && run_osc;
	end

	// comparator: counter against reference
	assign t0_eq    = (timer_count_r == timer_reference_value_r);
	assign t0_match = t0_tick && t0_eq && !t0_clr
	                  && (t0_mode == MODE_INTERVAL || t0_mode == MODE_PWM);
	assign t0_wrap  = t0_tick && !t0_clr && (timer_count_r == CNT_MAX)
	                  && !(t0_mode == MODE_INTERVAL && t0_eq);
	assign cap_edge = (t0_mode == MODE_CAP_RISE && timer_capture_pin && !cap_prev_r)
	               || (t0_mode == MODE_CAP_FALL && !timer_capture_pin && cap_prev_r);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_prev_r <= 1'b0;
			cap_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= timer_ext_clock_pin;
			cap_prev_r <= timer_capture_pin;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_control_r <= REG_RESET;
		end else if (wr_t0_ctl) begin
			// bit 3 is a strobe and bit 0 lives in the pending flop
			timer_control_r <= reg_wdata & T0_STORE_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_count_r <= CNT_ZERO;
		end else if (t0_clr) begin
			timer_count_r <= CNT_ZERO;
		end else if (t0_tick) begin
			if (t0_mode == MODE_INTERVAL && t0_eq) begin
				timer_count_r <= CNT_ZERO;
			end else begin
				timer_count_r <= timer_count_r + CNT_ONE;
			end
		end
	end

	// a capture in the same cycle as a software write wins: the edge is real data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_reference_value_r <= REG_RESET;
		end else if (cap_edge) begin
			timer_reference_value_r <= timer_count_r;
		end else if (wr_t0_ref) begin
			timer_reference_value_r <= reg_wdata;
		end
	end

	// set wins over the software clear so a same-cycle event is not lost
	always_comb begin
		match_pend_nxt = match_pend_r;
		if (wr_t0_ctl && !reg_wdata[T0_PEND_BIT]) begin
			match_pend_nxt = 1'b0;
		end
		if (t0_match || cap_edge) begin
			match_pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			match_pend_r            <= 1'b0;
			timer_match_interrupt_r <= 1'b0;
		end else begin
			match_pend_r            <= match_pend_nxt;
			timer_match_interrupt_r <= match_pend_nxt && timer_control_r[T0_MATCH_EN_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_wrap_interrupt_r <= 1'b0;
		end else if (t0_wrap && timer_control_r[T0_WRAP_EN_BIT]) begin
			timer_wrap_interrupt_r <= 1'b1;
		end else if (wrap_ack) begin
			timer_wrap_interrupt_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			timer_pulse_output_r <= 1'b0;
		end else if (t0_mode == MODE_PWM) begin
			timer_pulse_output_r <= (timer_reference_value_r > timer_count_r);
		end else if (t0_match) begin
			timer_pulse_output_r <= !timer_pulse_output_r;
		end
	end

	// read port: answer one cycle after the strobe, unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_r <= REG_RESET;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_T0_REF: reg_rdata_r <= timer_reference_value_r;
				ADDR_T0_CTL: reg_rdata_r <= timer_control_r | {7'h00, match_pend_r};
				ADDR_WD_CTL: reg_rdata_r <= watchdog_control_r;
				ADDR_WD_CNT: reg_rdata_r <= watchdog_count_r;
				default:     reg_rdata_r <= REG_RESET;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_wd_reset;
		wd_wrap && wd_en |-> ##1 wdt_reset_r;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("watchdog wrap gave no reset");

	property p_wd_disabled;
		$rose(wdt_reset_r) |-> $past(watchdog_control_r[WD_EN_HI:WD_EN_LO]) != WD_DISABLE;
	endproperty
	a_wd_disabled: assert property (p_wd_disabled) else $error("reset while watchdog off");

	property p_wd_clear;
		wd_clr |-> ##1 watchdog_count_r == CNT_ZERO;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("watchdog count not cleared");

	property p_stab_end;
		stab_end |-> ##1 (!cpu_clock_hold_r && stab_done_r && state_r == WD_RUN);
	endproperty
	a_stab_end: assert property (p_stab_end) else $error("cpu clock not released");

	property p_stop_osc;
		state_r == WD_STOP && ext_wake |-> ##1 osc_run_r ##1 osc_run_r;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("oscillator not restarted");

	property p_interval_clear;
		t0_tick && t0_eq && t0_mode == MODE_INTERVAL |-> ##1 timer_count_r == CNT_ZERO;
	endproperty
	a_interval_clear: assert property (p_interval_clear) else $error("match did not clear");

	property p_t0_clear;
		t0_clr |-> ##1 (timer_count_r == CNT_ZERO);
	endproperty
	a_t0_clear: assert property (p_t0_clear) else $error("timer count not cleared");

	property p_pend_clear;
		wr_t0_ctl && !reg_wdata[T0_PEND_BIT] && !t0_match && !cap_edge |-> ##1 !match_pend_r;
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("pending bit not cleared");

	property p_pwm_out;
		t0_mode == MODE_PWM ##1 t0_mode == MODE_PWM |->
			timer_pulse_output_r == ($past(timer_reference_value_r) > $past(timer_count_r));
	endproperty
	a_pwm_out: assert property (p_pwm_out) else $error("pwm level wrong");

	property p_capture;
		cap_edge |-> ##1 (timer_reference_value_r == $past(timer_count_r) && match_pend_r);
	endproperty
	a_capture: assert property (p_capture) else $error("capture not loaded");

	property p_clr_reads_zero;
		reg_rd && reg_addr == ADDR_T0_CTL |-> ##1 !reg_rdata_r[T0_CNT_CLR_BIT];
	endproperty
	a_clr_reads_zero: assert property (p_clr_reads_zero) else $error("clear bit read as one");

	property p_wrap_irq;
		t0_wrap && timer_control_r[T0_WRAP_EN_BIT] |-> ##1 timer_wrap_interrupt_r;
	endproperty
	a_wrap_irq: assert property (p_wrap_irq) else $error("overflow interrupt missing");
endmodule // wdt0_unit

//--- src/wdt0_pkg.sv
/*
 package for the watchdog and timer 0 unit: register map, field positions,
 reset values, clock-select and mode codes, prescaler taps, state type.
 assumes the oscillator clock is the module clock and registers sit on the
 cpu register-addressing port (8-bit address, 8-bit data).
*/
package wdt0_pkg;
	localparam int          REG_W          = 8;
	localparam logic [7:0]  ADDR_T0_REF    = 8'hd1;
	localparam logic [7:0]  ADDR_T0_CTL    = 8'hd2;
	localparam logic [7:0]  ADDR_WD_CTL    = 8'hd3;
	localparam logic [7:0]  ADDR_WD_CNT    = 8'hfd;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [7:0]  CNT_ZERO       = 8'h00;
	localparam logic [7:0]  CNT_ONE        = 8'h01;
	localparam logic [7:0]  CNT_MAX        = 8'hff;

	// watchdog control fields
	localparam int          WD_EN_HI       = 7;
	localparam int          WD_EN_LO       = 4;
	localparam int          WD_SEL_HI      = 3;
	localparam int          WD_SEL_LO      = 2;
	localparam int          WD_CNT_CLR_BIT = 1;
	localparam int          DIV_CLR_BIT    = 0;
	localparam logic [3:0]  WD_DISABLE     = 4'ha;
	localparam logic [7:0]  WD_STORE_MASK  = 8'hfc;
	localparam logic [1:0]  WD_SEL_4096    = 2'h0;
	localparam logic [1:0]  WD_SEL_1024    = 2'h1;
	localparam logic [1:0]  WD_SEL_128     = 2'h2;
	localparam logic [1:0]  WD_SEL_16384   = 2'h3;
	localparam int          STAB_BIT       = 3;
	localparam logic [3:0]  STAB_LOW_FULL  = 4'hf;

	// timer control fields
	localparam int          T0_SEL_HI      = 7;
	localparam int          T0_SEL_LO      = 6;
	localparam int          T0_MODE_HI     = 5;
	localparam int          T0_MODE_LO     = 4;
	localparam int          T0_CNT_CLR_BIT = 3;
	localparam int          T0_WRAP_EN_BIT = 2;
	localparam int          T0_MATCH_EN_BIT = 1;
	localparam int          T0_PEND_BIT    = 0;
	localparam logic [7:0]  T0_STORE_MASK  = 8'hf6;
	localparam logic [1:0]  T0_SEL_4096    = 2'h0;
	localparam logic [1:0]  T0_SEL_256     = 2'h1;
	localparam logic [1:0]  T0_SEL_8       = 2'h2;
	localparam logic [1:0]  T0_SEL_EXT     = 2'h3;
	localparam logic [1:0]  MODE_INTERVAL  = 2'h0;
	localparam logic [1:0]  MODE_CAP_RISE  = 2'h1;
	localparam logic [1:0]  MODE_CAP_FALL  = 2'h2;
	localparam logic [1:0]  MODE_PWM       = 2'h3;

	// shared prescaler: tap k pulses once every 2**PS_TAP_EXP[k] clocks
	localparam int          PS_WIDTH       = 14;
	localparam int          PS_TAPS        = 6;
	localparam int          PS_TAP_EXP [PS_TAPS] = '{3, 7, 8, 10, 12, 14};
	localparam int          TAP_8          = 0;
	localparam int          TAP_128        = 1;
	localparam int          TAP_256        = 2;
	localparam int          TAP_1024       = 3;
	localparam int          TAP_4096       = 4;
	localparam int          TAP_16384      = 5;
	localparam logic [13:0] PS_ONE         = 14'h0001;

	typedef enum logic [1:0] {WD_RUN, WD_STOP, WD_STAB} wdt0_state_t;
endpackage

//--- src/wdt0_prescaler.sv
/*
 shared frequency divider for the watchdog and timer 0.
 assumes clk is the oscillator clock; clear is a one-cycle strobe.
*/
`timescale 1ns/100ps
module wdt0_prescaler (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        clear,
	output wire logic [wdt0_pkg::PS_TAPS-1:0] tick
);
	import wdt0_pkg::*;

	logic [PS_WIDTH-1:0] div_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= '0;
		end else if (clear) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + PS_ONE;
		end
	end

	// no tick in the clearing cycle, so a cleared divider restarts a full period
	for (genvar g = 0; g < PS_TAPS; g++) begin : g_tap
		assign tick[g] = !clear && (&div_r[PS_TAP_EXP[g]-1:0]);
	end
endmodule // wdt0_prescaler

//--- verif/wdt0_pin_model.sv
/*
 pin-side partner of the timer: external clock source and capture input.
 assumes the bench asks for clock bursts and capture levels by plain flags.
*/
`timescale 1ns/100ps
module wdt0_pin_model (
	input  wire logic clk,
	input  wire logic ck_en,
	input  wire logic cap_lvl,
	output logic      ext_ck,
	output logic      cap_pin
);
	int unsigned ph = 0;
	logic        ck_en_q = 1'b0;
	logic        cap_lvl_q = 1'b0;

	// the bench moves its flags on the falling edge, so take them on the rising
	// edge first; reading them on that same falling edge would race the bench
	always @(posedge clk) begin
		ck_en_q <= ck_en;
		cap_lvl_q <= cap_lvl;
	end

	// period of ten clocks; the clock stands still low outside a burst
	always @(negedge clk) begin
		ph <= ck_en_q ? (ph + 1) % 10 : 0;
		ext_ck <= ck_en_q && (ph >= 5);
		cap_pin <= cap_lvl_q;
	end
endmodule // wdt0_pin_model

//--- verif/wdt0_unit_tb_top.sv
/*
 self-checking bench for the watchdog and timer 0 unit.
 assumes the design's own assertions run beside it; pins come from the model.
*/
`timescale 1ns/100ps
module wdt0_unit_tb_top;
	import wdt0_pkg::*;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata_r;
	logic       stop_req = 1'b0;
	logic       ext_wake = 1'b0;
	logic       wrap_ack = 1'b0;
	logic       ck_en = 1'b0;
	logic       cap_lvl = 1'b0;
	logic       osc_run_r, cpu_clock_hold_r, stab_done_r, wdt_reset_r;
	logic       ext_ck, cap_pin, wrap_irq, match_irq, pulse_out, p;
	logic [7:0] d, ref_v;
	int         error_cnt = 0;
	int         total_checks = 0;
	int         wd_seen = 0;
	int         n, hi;

	always #10 clk = ~clk;

	always @(posedge clk) begin
		if (wdt_reset_r === 1'b1) wd_seen++;
	end

	wdt0_unit i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.stop_req(stop_req), .ext_wake(ext_wake), .osc_run_r(osc_run_r),
		.cpu_clock_hold_r(cpu_clock_hold_r), .stab_done_r(stab_done_r),
		.wdt_reset_r(wdt_reset_r), .timer_ext_clock_pin(ext_ck),
		.timer_capture_pin(cap_pin), .wrap_ack(wrap_ack),
		.timer_wrap_interrupt_r(wrap_irq), .timer_match_interrupt_r(match_irq),
		.timer_pulse_output_r(pulse_out));

	wdt0_pin_model i_pins (.clk(clk), .ck_en(ck_en), .cap_lvl(cap_lvl), .ext_ck(ext_ck),
		.cap_pin(cap_pin));

	function automatic int div_of(input logic [1:0] s);
		// the model's external clock has a ten-clock period
		return (s == T0_SEL_256) ? 256 : (s == T0_SEL_8) ? 8 : 10;
	endfunction

	function automatic int pwm_hi(input logic [7:0] r);
		return int'(r) * 8;
	endfunction

	function automatic logic pick(input int s);
		case (s)
			0: return match_irq === 1'b1;
			1: return wrap_irq === 1'b1;
			2: return stab_done_r === 1'b1;
			default: return wdt_reset_r === 1'b1;
		endcase
	endfunction

	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		v = reg_rdata_r;
	endtask

	// bounded wait, so a dead output cannot hang the run
	task automatic wait_for(input int s, input int lim, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (c < lim && !pick(s));
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#(130000 * 20);
		error_cnt++;
		results;
	end

	initial begin
		void'($urandom(47));
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		rd(ADDR_T0_REF, d);
		chk8("ref_rst", REG_RESET, d);
		rd(ADDR_T0_CTL, d);
		chk8("ctl_rst", REG_RESET, d);
		rd(ADDR_WD_CTL, d);
		chk8("wdc_rst", REG_RESET, d);
		rd(8'h00, d);
		chk8("unmapped", 8'h00, d);
		chk1("hold_on", 1'b1, cpu_clock_hold_r);
		wait_for(2, 70000, n);
		chk1("stab_len", 1'b1, n > 65000 && n < 66000);
		repeat (2) @(negedge clk);
		chk1("hold_off", 1'b0, cpu_clock_hold_r);
		wr(ADDR_WD_CTL, 8'hab);
		rd(ADDR_WD_CTL, d);
		chk8("wdc_rb", 8'ha8, d);
		ck_en = 1'b1;
		for (int s = 1; s < 4; s++) begin
			wr(ADDR_T0_REF, 8'h02);
			wr(ADDR_T0_CTL, {s[1:0], MODE_INTERVAL, 4'ha});
			// sampled after the clear: the old setting can no longer toggle the pin
			p = pulse_out;
			wait_for(0, 2000, n);
			chk1("toggle", ~p, pulse_out);
			chk1("ivl_time", 1'b1, n >= 2 * div_of(s[1:0]) - 2 && n <= 3 * div_of(s[1:0]) + 3);
			rd(ADDR_T0_CTL, d);
			chk8("pend", {s[1:0], MODE_INTERVAL, 4'h3}, d);
			wr(ADDR_T0_CTL, {s[1:0], MODE_INTERVAL, 4'h2});
			chk1("pend_clr", 1'b0, match_irq);
		end
		ck_en = 1'b0;
		for (int m = 1; m < 3; m++) begin
			cap_lvl = (m == 2);
			repeat (3) @(negedge clk);
			wr(ADDR_T0_REF, 8'hff);
			wr(ADDR_T0_CTL, {T0_SEL_8, m[1:0], 4'ha});
			repeat (40) @(negedge clk);
			cap_lvl = (m == 1);
			wait_for(0, 10, n);
			chk1("cap_irq", 1'b1, match_irq);
			rd(ADDR_T0_REF, d);
			chk1("cap_val", 1'b1, d >= 8'h03 && d <= 8'h07);
			wr(ADDR_T0_CTL, {T0_SEL_8, m[1:0], 4'h2});
			cap_lvl = (m == 2);
			repeat (5) @(negedge clk);
			chk1("cap_wrong_edge", 1'b0, match_irq);
		end
		repeat (2100) @(negedge clk);
		chk1("wrap_off", 1'b0, wrap_irq);
		wr(ADDR_T0_CTL, {T0_SEL_8, MODE_CAP_RISE, 4'h4});
		wait_for(1, 2100, n);
		chk1("wrap_on", 1'b1, wrap_irq);
		wrap_ack = 1'b1;
		@(negedge clk);
		wrap_ack = 1'b0;
		chk1("wrap_ack", 1'b0, wrap_irq);
		ref_v = 8'($urandom_range(254, 1));
		wr(ADDR_T0_REF, ref_v);
		wr(ADDR_T0_CTL, {T0_SEL_8, MODE_PWM, 4'h2});
		repeat (8) @(negedge clk);
		hi = 0;
		repeat (2048) begin
			@(negedge clk);
			hi += int'(pulse_out);
		end
		chk1("pwm_duty", 1'b1, hi == pwm_hi(ref_v));
		rd(ADDR_T0_CTL, d);
		chk1("pwm_match", 1'b1, d[0]);
		chk1("match_irq_on", 1'b1, match_irq);
		wr(ADDR_T0_CTL, {T0_SEL_8, MODE_PWM, 4'h1});
		@(negedge clk);
		chk1("match_irq_off", 1'b0, match_irq);
		wr(ADDR_WD_CTL, 8'ha8);
		@(negedge clk);
		stop_req = 1'b1;
		@(negedge clk);
		stop_req = 1'b0;
		chk1("osc_off", 1'b0, osc_run_r);
		repeat (20) @(negedge clk);
		ext_wake = 1'b1;
		@(negedge clk);
		ext_wake = 1'b0;
		chk1("osc_on", 1'b1, osc_run_r);
		wait_for(2, 3000, n);
		chk1("stab_sel", 1'b1, n >= 1900 && n <= 2060);
		chk1("no_wd_reset", 1'b1, wd_seen == 0);
		// enable, /128 and counter clear in one write
		wr(ADDR_WD_CTL, 8'h0a);
		wait_for(3, 33500, n);
		chk1("wd_period", 1'b1, n >= 32640 && n <= 32780);
		rd(ADDR_WD_CNT, d);
		chk8("wd_wrap_cnt", CNT_ZERO, d);
		results;
	end
endmodule // wdt0_unit_tb_top
